// [verilog/cmt_tables.sv]
`timescale 1ns/1ns
module cmt_tables #(
	parameter int unsigned WIDTH = cmt_pkg::DATA_W,
	parameter int unsigned WORDS = cmt_pkg::DEPTH
) (
	// clock and reset
	input  wire logic                 ref_clk_i,
	input  wire logic                 resetn_i,
	// shared write data from bus receivers
	input  wire cmt_pkg::cmt_word_t   bus_wdata_i,
	// write strobes, active low
	input  wire logic                 detect_mem_write_strobe_n_i,
	input  wire logic                 action_mem_write_strobe_n_i,
	// read drive enable for detect word
	input  wire logic                 detect_mem_read_drive_i,
	// step counter control
	input  wire logic                 step_advance_i,
	input  wire logic                 step_load_i,
	input  wire cmt_pkg::cmt_addr_t   step_load_value_i,
	input  wire logic                 rx_active_i,
	input  wire logic                 tx_active_i,
	// character sources
	input  wire logic                 rx_search_i,
	input  wire cmt_pkg::cmt_word_t   rx_buffer_i,
	input  wire cmt_pkg::cmt_word_t   tx_holding_i,
	input  wire logic                 tx_holding_load_strobe_i,
	// flag acknowledge from receive status read
	input  wire logic                 char_flag_clear_i,
	input  wire logic                 hit_test_i,
	// match results
	output logic                      low_byte_hit_o,
	output logic                      high_byte_hit_o,
	output logic                      word_hit_o,
	output logic                      saved_word_hit_o,
	output logic                      pair_hit_override_n_o,
	// readback and status
	output cmt_pkg::cmt_word_t        detect_read_o,
	output logic                      detect_read_en_o,
	output cmt_pkg::cmt_word_t        action_table_read_o,
	output cmt_pkg::cmt_addr_t        table_step_counter_o,
	output logic                      char_flag_o,
	output cmt_pkg::cmt_addr_t        hit_index_o
);
	import cmt_pkg::*;

	// ==========================================================
	// storage; no reset, contents are software owned
	cmt_word_t detect_mem [WORDS];
	cmt_word_t action_table [WORDS];

	cmt_addr_t         step_q;
	cmt_addr_t         step_d;
	logic [BYTE_W-1:0] hold_q;
	logic [BYTE_W-1:0] hold_d;
	logic              flag_q;
	logic              flag_d;
	cmt_addr_t         idx_q;
	cmt_addr_t         idx_d;
	cmt_word_t         det_rd_q;
	cmt_word_t         det_rd_d;
	cmt_word_t         act_rd_q;
	cmt_word_t         act_rd_d;
	logic              any_hit;
	logic              idle;

	cmt_cmp_if cif ();

	// ==========================================================
	// memory writes, strobes independent on a shared address and data path
	always_ff @(posedge ref_clk_i) begin
		if (!detect_mem_write_strobe_n_i) begin
			detect_mem[step_q] <= bus_wdata_i;
		end
		if (!action_mem_write_strobe_n_i) begin
			action_table[step_q] <= bus_wdata_i;
		end
	end

	// ==========================================================
	// comparator feed; reads are non destructive array lookups
	assign cif.detect_word = detect_mem[step_q];
	assign cif.action_word = action_table[step_q];
	assign cif.source_word = rx_search_i ? rx_buffer_i : tx_holding_i;
	assign cif.saved_high  = hold_q;
	assign cif.rx_search   = rx_search_i;

	cmt_compare u_cmp (
		.c (cif.cmp_side)
	);

	assign low_byte_hit_o        = cif.low_byte_hit;
	assign high_byte_hit_o       = cif.high_byte_hit;
	assign word_hit_o            = cif.word_hit;
	assign saved_word_hit_o      = cif.saved_word_hit;
	assign pair_hit_override_n_o = cif.pair_hit_override_n;
	assign any_hit = cif.low_byte_hit | cif.high_byte_hit | cif.word_hit | cif.saved_word_hit;
	assign idle    = ~rx_active_i & ~tx_active_i;

	// ==========================================================
	// next state for counter, hold byte, flag and readback
	always_comb begin
		step_d   = step_q;
		hold_d   = hold_q;
		flag_d   = flag_q;
		idx_d    = idx_q;
		det_rd_d = cif.detect_word;
		act_rd_d = cif.action_word;
		// load only when both directions idle so a search is never disturbed
		if (step_load_i && idle) begin
			step_d = step_load_value_i;
		end else if (step_advance_i) begin
			step_d = cmt_addr_t'(step_q + STEP_ONE); // wraps 15 to 0
		end
		if (tx_holding_load_strobe_i) begin
			hold_d = tx_holding_i[DATA_W-1:BYTE_W];
		end
		if (char_flag_clear_i) begin
			flag_d = 1'b0;
		end
		// set placed after clear so a coincident hit wins
		if (hit_test_i && rx_search_i && any_hit &&
			(cif.action_word[ACT_FLAG_B12] || cif.action_word[ACT_FLAG_B13])) begin
			flag_d = 1'b1;
			idx_d  = step_q;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			step_q   <= STEP_RESET;
			hold_q   <= HOLD_RESET;
			flag_q   <= 1'b0;
			idx_q    <= STEP_RESET;
			det_rd_q <= WORD_RESET;
			act_rd_q <= WORD_RESET;
		end else begin
			step_q   <= step_d;
			hold_q   <= hold_d;
			flag_q   <= flag_d;
			idx_q    <= idx_d;
			det_rd_q <= det_rd_d;
			act_rd_q <= act_rd_d;
		end
	end

	assign table_step_counter_o = step_q;
	assign char_flag_o          = flag_q;
	assign hit_index_o          = idx_q;
	assign detect_read_o        = det_rd_q;
	assign detect_read_en_o     = detect_mem_read_drive_i; // drivers enabled by decode
	assign action_table_read_o  = act_rd_q;
endmodule

// [verilog/cmt_pkg.sv]
// Behaviour
// - two 16x16 memories, reads never alter contents
// - compare source with the detect word addressed by the step counter
// - shared 4-bit wrapping step counter addresses both
// - separate write strobes, common address
// - low strobe writes; readback is sampled every cycle, with a separate read drive enable
// - one shared 16-bit write data path
// - both memory words readable by software
// - receive: high byte and word compares
// - transmit: four simultaneous compares
// - hold tx high byte on holding load
// - receive search selects receive buffer source
// - bitwise equality, per-byte all-equal results
// - byte hits need bit 15, no pair
// - pair override on word hit with bit 14
// - word hits need action bit 15
// - receive hit with bit 12/13 flags, latches index
// - counter load only when rx and tx idle
package cmt_pkg;
	// ==========================================================
	// geometry
	localparam int unsigned DATA_W    = 16;
	localparam int unsigned ADDR_W    = 4;
	localparam int unsigned DEPTH     = 16;
	localparam int unsigned BYTE_W    = 8;
	// ==========================================================
	// action word fields
	localparam int unsigned ACT_ENABLE_BIT = 15;
	localparam int unsigned ACT_PAIR_BIT   = 14;
	localparam int unsigned ACT_FLAG_B13   = 13;
	localparam int unsigned ACT_FLAG_B12   = 12;
	// ==========================================================
	// reset values and counter step
	localparam logic [ADDR_W-1:0] STEP_RESET  = 4'h0;
	localparam logic [BYTE_W-1:0] HOLD_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] WORD_RESET  = 16'h0000;
	localparam logic [ADDR_W-1:0] STEP_ONE    = 4'h1;

	typedef logic [DATA_W-1:0] cmt_word_t;
	typedef logic [ADDR_W-1:0] cmt_addr_t;
endpackage

// [verilog/cmt_cmp_if.sv]
`timescale 1ns/1ns
// carries the addressed words and the source into the comparator
interface cmt_cmp_if;
	import cmt_pkg::*;
	cmt_word_t        detect_word;
	cmt_word_t        action_word;
	cmt_word_t        source_word;
	logic [BYTE_W-1:0] saved_high;
	logic             rx_search;
	logic             low_byte_hit;
	logic             high_byte_hit;
	logic             word_hit;
	logic             saved_word_hit;
	logic             pair_hit_override_n;
	modport table_side (output detect_word, action_word, source_word, saved_high, rx_search,
		input low_byte_hit, high_byte_hit, word_hit, saved_word_hit, pair_hit_override_n);
	modport cmp_side (input detect_word, action_word, source_word, saved_high, rx_search,
		output low_byte_hit, high_byte_hit, word_hit, saved_word_hit, pair_hit_override_n);
endinterface

// [verilog/cmt_compare.sv]
`timescale 1ns/1ns
module cmt_compare (
	cmt_cmp_if.cmp_side c
);
	import cmt_pkg::*;

	// ==========================================================
	// bytewise equality
	function automatic logic byte_eq(input logic [BYTE_W-1:0] a, input logic [BYTE_W-1:0] b);
		byte_eq = &(~(a ^ b)); // all bits must agree
	endfunction

	logic [BYTE_W-1:0] det_lo;
	logic [BYTE_W-1:0] det_hi;
	logic [BYTE_W-1:0] src_lo;
	logic [BYTE_W-1:0] src_hi;
	logic              hi_eq;
	logic              lo_eq;
	logic              lo_vs_dhi;
	logic              saved_eq;
	logic              en;
	logic              pair;

	// ==========================================================
	// compare and decode, purely combinational so results settle per step
	always_comb begin
		det_lo    = c.detect_word[BYTE_W-1:0];
		det_hi    = c.detect_word[DATA_W-1:BYTE_W];
		src_lo    = c.source_word[BYTE_W-1:0];
		src_hi    = c.source_word[DATA_W-1:BYTE_W];
		hi_eq     = byte_eq(src_hi, det_hi);
		lo_eq     = byte_eq(src_lo, det_lo);
		lo_vs_dhi = byte_eq(src_lo, det_hi) & ~c.rx_search; // tx only
		// previous high byte against detect low, current low against detect high
		saved_eq  = byte_eq(c.saved_high, det_lo) & lo_vs_dhi;
		en        = c.action_word[ACT_ENABLE_BIT];
		c.word_hit       = en & hi_eq & lo_eq;
		c.saved_word_hit = en & saved_eq;
		pair      = (c.word_hit | c.saved_word_hit) & c.action_word[ACT_PAIR_BIT];
		c.pair_hit_override_n = ~pair;
		// double matches win over single characters only when action bit 14 is set
		c.high_byte_hit = en & hi_eq & ~pair;
		c.low_byte_hit  = en & lo_vs_dhi & ~pair;
	end
endmodule

// [verification/cmt_tables_chk.sv]
`timescale 1ns/1ns
// =====
// port watcher for the match tables
module cmt_tables_chk (
	// clock and reset
	input wire logic		ref_clk_i,
	input wire logic		resetn_i,
	// counter, source and write controls
	input wire logic		step_advance_i,
	input wire logic		step_load_i,
	input wire cmt_pkg::cmt_addr_t	step_load_value_i,
	input wire logic		rx_active_i,
	input wire logic		tx_active_i,
	input wire logic		rx_search_i,
	input wire cmt_pkg::cmt_word_t	rx_buffer_i,
	input wire cmt_pkg::cmt_word_t	tx_holding_i,
	input wire logic		detect_mem_write_strobe_n_i,
	input wire logic		tx_holding_load_strobe_i,
	// results
	input wire logic		low_byte_hit_o,
	input wire logic		high_byte_hit_o,
	input wire logic		word_hit_o,
	input wire logic		saved_word_hit_o,
	input wire logic		pair_hit_override_n_o,
	input wire cmt_pkg::cmt_word_t	detect_read_o,
	input wire cmt_pkg::cmt_addr_t	table_step_counter_o
);
	import cmt_pkg::*;
	// the word the selector ought to route
	cmt_word_t src;
	assign src = rx_search_i ? rx_buffer_i : tx_holding_i;
	// own copy of the previous transmit high byte, kept from the load strobe
	logic [7:0] saved_hi;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			saved_hi <= 8'h00;
		end else if (tx_holding_load_strobe_i) begin
			saved_hi <= tx_holding_i[15:8];
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	// readback lags a cycle, so trust it only once counter and table sat still
	sequence s_cur;
		$stable(table_step_counter_o) && $past(detect_mem_write_strobe_n_i) && $past(resetn_i);
	endsequence
	property p_excl; !pair_hit_override_n_o |-> !low_byte_hit_o && !high_byte_hit_o; endproperty
	a_excl: assert property (p_excl) else $error("byte hit under pair override");
	property p_hi; s_cur ##0 high_byte_hit_o |-> src[15:8] == detect_read_o[15:8]; endproperty
	a_hi: assert property (p_hi) else $error("high byte hit on unequal bytes");
	property p_word; s_cur ##0 word_hit_o |-> src == detect_read_o; endproperty
	a_word: assert property (p_word) else $error("word hit on unequal words");
	property p_low; s_cur ##0 low_byte_hit_o |-> !rx_search_i &&
		tx_holding_i[7:0] == detect_read_o[15:8]; endproperty
	a_low: assert property (p_low) else $error("low byte hit wrong");
	property p_sav; s_cur ##0 saved_word_hit_o |-> !rx_search_i &&
		tx_holding_i[7:0] == detect_read_o[15:8] && saved_hi == detect_read_o[7:0]; endproperty
	a_sav: assert property (p_sav) else $error("saved word hit wrong");
	property p_adv; step_advance_i && !(step_load_i && !rx_active_i && !tx_active_i) |=>
		table_step_counter_o == $past(table_step_counter_o) + 4'h1; endproperty
	a_adv: assert property (p_adv) else $error("counter step wrong");
	property p_ref; step_load_i && (rx_active_i || tx_active_i) && !step_advance_i |=>
		$stable(table_step_counter_o); endproperty
	a_ref: assert property (p_ref) else $error("load taken while active");
	property p_load; step_load_i && !rx_active_i && !tx_active_i |=>
		table_step_counter_o == $past(step_load_value_i); endproperty
	a_load: assert property (p_load) else $error("counter load lost");
endmodule

// [verification/cmt_line_model.sv]
`timescale 1ns/1ns
// =====
// line side: receive buffer and transmit shift-hold register
module cmt_line_model (
	// clock
	input wire logic		ref_clk_i,
	// character words toward the tables
	output cmt_pkg::cmt_word_t	rx_buffer_o,
	output cmt_pkg::cmt_word_t	tx_holding_o,
	output logic			tx_holding_load_strobe_o
);
	import cmt_pkg::*;
	// both registers start empty
	initial begin
		rx_buffer_o = 16'h0000;
		tx_holding_o = 16'h0000;
		tx_holding_load_strobe_o = 1'h0;
	end
	// each byte holds one character of 8 bits or fewer
	task automatic rx_word(cmt_word_t w);
		rx_buffer_o = w;
	endtask
	// the load pulse comes while the old word still shows, so the hold keeps it
	task automatic tx_word(cmt_word_t w);
		tx_holding_load_strobe_o = 1'h1;
		@(negedge ref_clk_i);
		tx_holding_load_strobe_o = 1'h0;
		tx_holding_o = w;
		// let an edge pass so a following call never re-raises the strobe in this step
		@(negedge ref_clk_i);
	endtask
endmodule

// [verification/control_char_match_tables_test.sv]
`timescale 1ns/1ns
// =====
// checker rides on the tables
bind cmt_tables cmt_tables_chk chk (.ref_clk_i, .resetn_i, .step_advance_i, .step_load_i,
	.step_load_value_i, .rx_active_i, .tx_active_i, .rx_search_i, .rx_buffer_i, .tx_holding_i,
	.detect_mem_write_strobe_n_i, .tx_holding_load_strobe_i, .low_byte_hit_o, .high_byte_hit_o,
	.word_hit_o,
	.saved_word_hit_o, .pair_hit_override_n_o, .detect_read_o, .table_step_counter_o);
// =====
// bench for the match tables
module control_char_match_tables_test;
	import cmt_pkg::*;
	// inputs quiet at time zero, then line side and outputs
	logic ref_clk_i = 1'h0, resetn_i = 1'h0, dws_n = 1'h1, aws_n = 1'h1, rdrv = 1'h0;
	logic adv = 1'h0, ld = 1'h0, rxa = 1'h0, txa = 1'h0, rxs = 1'h0, clr = 1'h0, tst = 1'h0;
	cmt_word_t wd = 16'h0000, rxb, txh, drd, ard;
	cmt_addr_t lv = 4'h0, cnt, hidx;
	logic txl, lbh, hbh, wh, swh, ovr_n, den, flg;
	int n_errors = 0, n_tests = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	cmt_line_model line (.ref_clk_i, .rx_buffer_o(rxb), .tx_holding_o(txh),
		.tx_holding_load_strobe_o(txl));
	cmt_tables dut (.ref_clk_i, .resetn_i, .bus_wdata_i(wd), .detect_mem_write_strobe_n_i(dws_n),
		.action_mem_write_strobe_n_i(aws_n), .detect_mem_read_drive_i(rdrv), .step_advance_i(adv),
		.step_load_i(ld), .step_load_value_i(lv), .rx_active_i(rxa), .tx_active_i(txa),
		.rx_search_i(rxs), .rx_buffer_i(rxb), .tx_holding_i(txh), .tx_holding_load_strobe_i(txl),
		.char_flag_clear_i(clr), .hit_test_i(tst), .low_byte_hit_o(lbh), .high_byte_hit_o(hbh),
		.word_hit_o(wh), .saved_word_hit_o(swh), .pair_hit_override_n_o(ovr_n),
		.detect_read_o(drd), .detect_read_en_o(den), .action_table_read_o(ard),
		.table_step_counter_o(cnt), .char_flag_o(flg), .hit_index_o(hidx));
	// compare and count
	task automatic chk(cmt_word_t seen, cmt_word_t exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic tick(int n = 1);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// hits packed as low, high, word, saved, override
	task automatic hits(logic [4:0] e);
		chk({lbh, hbh, wh, swh, ovr_n}, e);
	endtask
	task automatic setp(cmt_addr_t a);
		lv = a;
		ld = 1'h1;
		tick();
		ld = 1'h0;
	endtask
	// point the counter, strobe one table, leave readback settled
	task automatic wr(cmt_addr_t a, cmt_word_t d, logic act);
		setp(a);
		wd = d;
		if (act) aws_n = 1'h0;
		else dws_n = 1'h0;
		tick();
		aws_n = 1'h1;
		dws_n = 1'h1;
		tick(2);
	endtask
	task automatic close_out();
		if (n_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// hang guard: the whole run is about 70 cycles
	initial begin
		#100000;
		n_errors++;
		close_out();
	end
	// main sequence
	initial begin
		tick(16);
		resetn_i = 1'h1;
		tick();
		chk(cnt, 4'h0);
		chk(den, 1'h0);
		wr(4'h2, 16'h4142, 1'h0);
		wr(4'h2, 16'h8000, 1'h1);
		chk(drd, 16'h4142);
		chk(ard, 16'h8000);
		wr(4'h3, 16'h5AA5, 1'h0);
		chk(drd, 16'h5AA5);
		setp(4'h2);
		rdrv = 1'h1;
		tick();
		chk(drd, 16'h4142);
		chk(den, 1'h1);
		rdrv = 1'h0;
		tick();
		chk(den, 1'h0);
		rxs = 1'h1;
		line.rx_word(16'h4142);
		tick();
		hits(5'h0D);
		line.rx_word(16'h4143);
		tick();
		hits(5'h09);
		line.rx_word(16'h4142);
		wr(4'h2, 16'hC000, 1'h1);
		hits(5'h04);
		wr(4'h2, 16'h0000, 1'h1);
		hits(5'h01);
		wr(4'h2, 16'h9000, 1'h1);
		tst = 1'h1;
		tick();
		tst = 1'h0;
		chk(flg, 1'h1);
		chk(hidx, 4'h2);
		clr = 1'h1;
		tick();
		clr = 1'h0;
		chk(flg, 1'h0);
		rxs = 1'h0;
		wr(4'h2, 16'h8000, 1'h1);
		line.tx_word(16'h42AA);
		line.tx_word(16'h7741);
		tick();
		hits(5'h13);
		wr(4'h2, 16'hC000, 1'h1);
		hits(5'h02);
		rxs = 1'h1;
		tick();
		hits(5'h04);
		rxs = 1'h0;
		line.tx_word(16'h4142);
		tick();
		hits(5'h04);
		setp(4'hE);
		adv = 1'h1;
		tick(2);
		adv = 1'h0;
		chk(cnt, 4'h0);
		for (int k = 0; k < 2; k++) begin
			{rxa, txa} = k ? 2'h1 : 2'h2;
			setp(4'h9);
			{rxa, txa} = 2'h0;
			chk(cnt, 4'h0);
		end
		setp(4'h9);
		chk(cnt, 4'h9);
		close_out();
	end
endmodule
